// ---- nvm_cmd_pkg.sv ----
// Functional notes
// R1 - Erase header: type 0x88, length 0x05
// R2 - 24-bit offset MSB first, base 0x11000000
// R3 - Erase type: 0 page, 1 sector, 2 all
// R4 - Never erase configuration sector pages
// R5 - Page/sector erase done within 5 ms
// R6 - Whole-memory erase done within 20 ms
// R7 - Reject whole erase if any region protected; reflash prepare (0x98) is accepted without this check
// R8 - Host uses whole erase only in production
// R9 - Erase errors reported by specific code
// R10 - Password header: type 0x89, length 0x06
// R11 - 32-bit password MSB first, then options
// R12 - Options 2:1 select region password
// R13 - Only store password; protection after reset
// R14 - All-ones or all-zeros password is invalid
// R15 - Existing password never changed directly
// R16 - Password/key response within 8 ms
// R17 - Protection gates read and write/erase per region
// R18 - Store key only when value matches
// R19 - Key options select mode and page
// R20 - Boot enters mode if any key valid
// R21 - Host repeats key for every page
// R22 - Key header: type 0x8A, length 0x06
// R23 - Only key 0xF155E01E accepted
// R24 - Rejection: error answer, memory untouched
package nvm_cmd_pkg;
    // Message header
    localparam logic [7:0] TYPE_ERASE = 8'h88;
    localparam logic [7:0] LEN_ERASE = 8'h05;
    localparam logic [7:0] TYPE_PWD = 8'h89;
    localparam logic [7:0] LEN_PWD = 8'h06;
    localparam logic [7:0] TYPE_KEY = 8'h8a;
    localparam logic [7:0] LEN_KEY = 8'h06;
    localparam logic [7:0] TYPE_PREP = 8'h98;
    localparam logic [31:0] SWITCH_KEY = 32'hf155e01e;
    localparam logic [31:0] MEM_BASE = 32'h11000000;
    // Erase types
    localparam logic [7:0] ER_PAGE = 8'h00;
    localparam logic [7:0] ER_SECTOR = 8'h01;
    localparam logic [7:0] ER_ALL = 8'h02;
    // Memory geometry
    localparam logic [23:0] MEM_SIZE = 24'h010000;
    localparam logic [23:0] CS_START = 24'h00f000;
    localparam int PAGE_BITS = 7;
    localparam int SECT_BITS = 12;
    // Option fields
    localparam int PSEL_LSB = 1;
    localparam int KSEL_LSB = 0;
    localparam int KID_LSB = 2;
    // Error codes
    localparam logic [7:0] ERR_NONE = 8'h00;
    localparam logic [7:0] ERR_SEMA = 8'h01;
    localparam logic [7:0] ERR_MODE = 8'h02;
    localparam logic [7:0] ERR_COUNT = 8'h03;
    localparam logic [7:0] ERR_WPROT = 8'h04;
    localparam logic [7:0] ERR_EPARAM = 8'h05;
    localparam logic [7:0] ERR_RANGE = 8'h06;
    localparam logic [7:0] ERR_CROSS = 8'h07;
    localparam logic [7:0] ERR_KEY = 8'h08;
    localparam logic [7:0] ERR_PWD_SET = 8'h09;
    localparam logic [7:0] ERR_TYPE = 8'h0a;
    // Timing
    localparam int CLK_HZ = 10_000_000;
    localparam int T_SHORT_MS = 5;
    localparam int T_LONG_MS = 20;
    localparam int T_CFG_MS = 8;
    localparam int CYC_SHORT = T_SHORT_MS * (CLK_HZ / 1000);
    localparam int CYC_LONG = T_LONG_MS * (CLK_HZ / 1000);
    localparam int CYC_CFG = T_CFG_MS * (CLK_HZ / 1000);
endpackage : nvm_cmd_pkg

// ---- nvm_erase_protect_commands.sv ----
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module nvm_erase_protect_commands #(
    parameter int CYC_SHORT_P = nvm_cmd_pkg::CYC_SHORT,
    parameter int CYC_LONG_P = nvm_cmd_pkg::CYC_LONG,
    parameter int CYC_CFG_P = nvm_cmd_pkg::CYC_CFG
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Memory engine status
    input wire logic sema_busy,
    input wire logic mode_ok,
    // Memory operation strobes
    output logic erase_go,
    output logic [31:0] erase_addr,
    output logic [1:0] erase_kind,
    output logic store_go,
    output logic [2:0] store_slot,
    output logic [31:0] store_data,
    // Boot-time results
    output logic [3:0] region_prot,
    output logic ram_mode,
    output logic mem_mode
);
    import nvm_cmd_pkg::*;

    // Register byte offsets
    localparam logic [11:0] A_RX = 12'h000;
    localparam logic [11:0] A_CTRL = 12'h004;
    localparam logic [11:0] A_STAT = 12'h008;
    localparam logic [11:0] A_PROT = 12'h00c;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_RECV = 4'b0010,
        ST_WAIT = 4'b0100,
        ST_DONE = 4'b1000
    } state_e;

    state_e state_q;
    logic [7:0] hdr_q [0:6]; // Received header bytes
    logic [2:0] cnt_q; // Bytes received
    logic [7:0] err_q; // Last answer code
    logic done_q; // Answer ready, cleared by software
    logic [23:0] timer_q; // Operation time budget
    // Non-volatile image: erased at power-up, untouched by reset
    logic [31:0] pwd_q [0:3] = '{default: 32'h0}; // Stored region passwords
    logic [3:0] pwd_set_q = 4'h0; // Valid password written since erase
    logic [31:0] key_q [0:2] = '{default: 32'h0}; // Switch key pages
    logic [1:0] kid_q [0:2] = '{default: 2'd0}; // Switch key ids per page
    logic [3:0] prot_q; // Applied protection
    logic ram_q, mem_q;
    logic boot_q; // Startup evaluation pending

    // Decoded header fields
    logic [7:0] mtype, mlen, etype, opts;
    logic [23:0] off;
    logic [31:0] word;
    assign mlen = hdr_q[0];
    assign mtype = hdr_q[1];
    assign off = {hdr_q[2], hdr_q[3], hdr_q[4]}; // R2
    assign etype = hdr_q[5];
    assign word = {hdr_q[2], hdr_q[3], hdr_q[4], hdr_q[5]}; // R11
    assign opts = hdr_q[6];

    // A password is only valid when neither all ones nor all zeros
    function automatic logic pwd_valid(input logic [31:0] p);
        pwd_valid = (p != 32'h00000000) && (p != 32'hffffffff); // R14
    endfunction : pwd_valid

    // Bytes expected for a message type, length byte included
    function automatic logic [2:0] msg_bytes(input logic [7:0] t);
        msg_bytes = (t == TYPE_ERASE) ? 3'd6 : 3'd7;
    endfunction : msg_bytes

    // APB access strobes; zero wait states
    logic wr_en, rd_en;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;

    // Header validation, in priority order
    logic [7:0] chk_err;
    logic [1:0] psel_f;
    logic [1:0] ksel_f;
    always_comb begin
        chk_err = ERR_NONE;
        psel_f = opts[PSEL_LSB +: 2]; // R12
        ksel_f = opts[KSEL_LSB +: 2];
        if (sema_busy) begin
            chk_err = ERR_SEMA; // R9
        end else if (!mode_ok) begin
            chk_err = ERR_MODE; // R9
        end else if (mtype == TYPE_ERASE) begin
            if (mlen != LEN_ERASE) begin
                chk_err = ERR_COUNT; // R1
            end else if (etype > ER_ALL) begin
                chk_err = ERR_EPARAM; // R3
            end else if (etype == ER_ALL && prot_q != 4'h0) begin
                chk_err = ERR_WPROT; // R7
            end else if (etype != ER_ALL && off >= MEM_SIZE) begin
                chk_err = ERR_RANGE; // R9
            end else if (etype != ER_ALL && off >= CS_START) begin
                chk_err = ERR_WPROT; // R4
            end else if (etype == ER_PAGE && off[PAGE_BITS-1:0] != '0) begin
                chk_err = ERR_CROSS; // R9
            end else if (etype == ER_SECTOR &&
                         off[SECT_BITS-1:0] != '0) begin
                chk_err = ERR_CROSS; // R9
            end
        end else if (mtype == TYPE_PWD) begin
            if (mlen != LEN_PWD) begin
                chk_err = ERR_COUNT; // R10
            end else if (pwd_set_q[psel_f]) begin
                chk_err = ERR_PWD_SET; // R15
            end
        end else if (mtype == TYPE_KEY) begin
            if (mlen != LEN_KEY) begin
                chk_err = ERR_COUNT; // R22
            end else if (word != SWITCH_KEY || ksel_f == 2'd3) begin
                chk_err = ERR_KEY; // R18 R23
            end
        end else if (mtype != TYPE_PREP) begin
            chk_err = ERR_TYPE;
        end
    end

    // Command sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            cnt_q <= 3'd0;
            timer_q <= 24'd0;
            err_q <= ERR_NONE;
            for (int i = 0; i < 7; i++) hdr_q[i] <= 8'h00;
        end else begin
            unique case (state_q)
                ST_IDLE, ST_RECV: begin
                    // Header bytes arrive one per write
                    if (wr_en && paddr == A_RX) begin
                        hdr_q[cnt_q] <= pwdata[7:0];
                        cnt_q <= cnt_q + 3'd1;
                        state_q <= ST_RECV;
                    end else if (state_q == ST_RECV && cnt_q >= 3'd2 &&
                                 cnt_q >= msg_bytes(mtype)) begin
                        cnt_q <= 3'd0;
                        err_q <= chk_err;
                        if (chk_err != ERR_NONE) begin
                            state_q <= ST_DONE; // R24
                        end else begin
                            state_q <= ST_WAIT;
                            // Reflash prepare is a whole erase too
                            if ((mtype == TYPE_ERASE && etype == ER_ALL) ||
                                mtype == TYPE_PREP)
                                timer_q <= 24'(CYC_LONG_P); // R6
                            else if (mtype == TYPE_ERASE)
                                timer_q <= 24'(CYC_SHORT_P); // R5
                            else
                                timer_q <= 24'(CYC_CFG_P); // R16
                        end
                    end
                end
                ST_WAIT: begin
                    // Answer is released when the budget runs out
                    if (timer_q <= 24'd1) begin
                        state_q <= ST_DONE;
                    end else begin
                        timer_q <= timer_q - 24'd1;
                    end
                end
                ST_DONE: begin
                    state_q <= ST_IDLE; // R24
                end
            endcase
        end
    end

    // Memory strobes issued on entry to the wait phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            erase_go <= 1'b0;
            erase_addr <= 32'h0;
            erase_kind <= 2'd0;
            store_go <= 1'b0;
            store_slot <= 3'd0;
            store_data <= 32'h0;
        end else begin
            erase_go <= 1'b0;
            store_go <= 1'b0;
            if (state_q == ST_RECV && !wr_en && cnt_q >= 3'd2 &&
                cnt_q >= msg_bytes(mtype) && chk_err == ERR_NONE) begin
                if (mtype == TYPE_ERASE || mtype == TYPE_PREP) begin
                    erase_go <= 1'b1; // R3
                    erase_addr <= MEM_BASE + {8'h00, off}; // R2
                    erase_kind <= (mtype == TYPE_PREP) ? 2'd2 : etype[1:0];
                end else begin
                    store_go <= 1'b1; // R13
                    store_data <= word;
                    store_slot <= (mtype == TYPE_PWD) ? {1'b0, psel_f}
                                                      : {1'b1, ksel_f};
                end
            end
        end
    end

    // Configuration sector image; no reset, it stands for flash cells
    // that must survive reset so stored protection applies after it
    always_ff @(posedge pclk) begin
        if (store_go && !store_slot[2]) begin
            pwd_q[store_slot[1:0]] <= store_data; // R13
            pwd_set_q[store_slot[1:0]] <= pwd_valid(store_data);
        end else if (store_go) begin
            key_q[store_slot[1:0]] <= store_data; // R18
            kid_q[store_slot[1:0]] <= opts[KID_LSB +: 2]; // R19
        end else if (erase_go && mtype == TYPE_PREP) begin
            // Reflash prepare: passwords cleared on the erase strobe, before the erase completes
            for (int i = 0; i < 4; i++) pwd_q[i] <= 32'h0; // R15
            pwd_set_q <= 4'h0;
        end
    end

    // Keys OR together: one valid key on any page is enough
    logic boot_ram, boot_mem;
    always_comb begin
        boot_ram = 1'b0;
        boot_mem = 1'b0;
        for (int i = 0; i < 3; i++) begin
            if (key_q[i] == SWITCH_KEY) begin
                boot_ram = boot_ram | kid_q[i][0]; // R20
                boot_mem = boot_mem | kid_q[i][1]; // R20
            end
        end
    end

    // Startup evaluation, once after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_q <= 1'b1;
            prot_q <= 4'h0;
            ram_q <= 1'b0;
            mem_q <= 1'b0;
        end else if (boot_q) begin
            boot_q <= 1'b0;
            // Image outlives reset, so earlier stores take effect here
            for (int i = 0; i < 4; i++)
                prot_q[i] <= pwd_valid(pwd_q[i]); // R14 R17
            ram_q <= boot_ram; // R20
            mem_q <= boot_mem; // R20
        end
    end

    // Boot results drive outputs; protection is frozen until reset
    assign region_prot = prot_q;
    assign ram_mode = ram_q;
    assign mem_mode = mem_q;

    // Answer flag: set wins over software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_q <= 1'b0;
        end else if (state_q == ST_DONE) begin
            done_q <= 1'b1;
        end else if (wr_en && paddr == A_CTRL && pwdata[0]) begin
            done_q <= 1'b0;
        end
    end

    // APB read data and answer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !(paddr == A_RX ||
                       paddr == A_CTRL || paddr == A_STAT ||
                       paddr == A_PROT);
            if (psel && !penable && !pwrite) begin
                unique case (paddr)
                    A_STAT: prdata <= {16'h0, err_q, 3'd0, done_q, state_q};
                    A_PROT: prdata <= {26'h0, mem_q, ram_q, prot_q};
                    default: prdata <= 32'h0;
                endcase
            end
        end
    end

    // Cycles spent waiting, and whether the running job is a short erase;
    // a counter because the budget is far beyond a delay range
    logic [23:0] wait_cnt_q;
    logic short_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_cnt_q <= 24'd0;
            short_q <= 1'b0;
        end else begin
            wait_cnt_q <= (state_q == ST_WAIT) ? wait_cnt_q + 24'd1 : 24'd0;
            if (erase_go) begin
                short_q <= (erase_kind != 2'd2);
            end else if (store_go) begin
                short_q <= 1'b0;
            end
        end
    end

    // Page or sector erase completes within the short budget
    a_erase_time: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == ST_WAIT && short_q) |-> wait_cnt_q < 24'(CYC_SHORT_P))
        else $error("erase answer late"); // R5
    a_store_key: assert property (@(posedge pclk) disable iff (!presetn)
        (store_go && store_slot[2]) |-> store_data == SWITCH_KEY)
        else $error("bad key stored"); // R18
    a_whole_prot: assert property (@(posedge pclk) disable iff (!presetn)
        (erase_go && erase_kind == 2'd2 && mtype == TYPE_ERASE)
        |-> prot_q == 4'h0) else $error("protected whole erase"); // R7
    a_cs_spared: assert property (@(posedge pclk) disable iff (!presetn)
        (erase_go && erase_kind != 2'd2) |-> erase_addr < MEM_BASE +
        {8'h00, CS_START}) else $error("config sector erased"); // R4
    a_reject_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        (state_q == ST_DONE && err_q != ERR_NONE) |->
        !erase_go && !store_go) else $error("rejected but acted"); // R24
    a_done_next: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ST_DONE |=> done_q) else $error("done flag lost"); // R24
    a_prot_stable: assert property (@(posedge pclk) disable iff (!presetn)
        !boot_q |=> $stable(prot_q)) else $error("protection moved"); // R13
    a_pwd_once: assert property (@(posedge pclk) disable iff (!presetn)
        (store_go && !store_slot[2]) |-> !pwd_set_q[store_slot[1:0]])
        else $error("password overwritten"); // R15
endmodule : nvm_erase_protect_commands
`default_nettype wire

// ---- mem_engine_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Memory engine stand-in: answers semaphore and mode, logs every strobe
module mem_engine_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bench requests for engine status
    input wire logic busy_req,
    input wire logic mode_req,
    // Strobes from the command block
    input wire logic erase_go,
    input wire logic [31:0] erase_addr,
    input wire logic [1:0] erase_kind,
    input wire logic store_go,
    input wire logic [2:0] store_slot,
    input wire logic [31:0] store_data,
    // Status back to the command block
    output logic sema_busy,
    output logic mode_ok
);
    int erase_n; // Erase strobes seen
    int store_n; // Store strobes seen
    logic [31:0] ea_q; // Last erase address
    logic [1:0] ek_q; // Last erase kind
    logic [2:0] ss_q; // Last store slot
    logic [31:0] sd_q; // Last stored word

    // Status follows the bench one cycle late, like a real engine
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sema_busy <= 1'b0;
            mode_ok <= 1'b0;
        end else begin
            sema_busy <= busy_req;
            mode_ok <= mode_req;
        end
    end

    // Log strobes; counts restart at reset so deltas are used
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            erase_n <= 0;
            store_n <= 0;
        end else begin
            if (erase_go === 1'b1) begin
                erase_n <= erase_n + 1;
                ea_q <= erase_addr;
                ek_q <= erase_kind;
            end
            if (store_go === 1'b1) begin
                store_n <= store_n + 1;
                ss_q <= store_slot;
                sd_q <= store_data;
            end
        end
    end
endmodule : mem_engine_model
`default_nettype wire

// ---- nvm_erase_protect_commands_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module nvm_erase_protect_commands_tb;
    import nvm_cmd_pkg::*;
    localparam int CS = 20; // Shortened page/sector erase time
    localparam int CL = 40; // Shortened whole erase time
    localparam int CC = 30; // Shortened store time
    localparam logic [11:0] A_RX = 12'h000;
    localparam logic [11:0] A_CTRL = 12'h004;
    localparam logic [11:0] A_STAT = 12'h008;
    localparam logic [11:0] A_PROT = 12'h00c;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, erase_addr, store_data, rdat;
    logic sema_busy, mode_ok, erase_go, store_go, ram_mode, mem_mode;
    logic [1:0] erase_kind;
    logic [2:0] store_slot;
    logic [3:0] region_prot;
    logic busy_req, mode_req, rerr;
    int fail_count, comparisons, cyc, en, sn;
    logic [23:0] goff[3] = '{24'h000080, 24'h001000, 24'h000000};
    int gcyc[3] = '{CS, CS, CL};
    logic [23:0] eoff[6] = '{24'h00f000, 24'h0, 24'h010000, 24'h000001,
                             24'h0, 24'h0};
    logic [7:0] etyp[6] = '{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] eerr[6] = '{ERR_WPROT, ERR_EPARAM, ERR_RANGE, ERR_CROSS,
                            ERR_SEMA, ERR_MODE};

    // Design under test with short timers
    nvm_erase_protect_commands #(.CYC_SHORT_P(CS), .CYC_LONG_P(CL),
        .CYC_CFG_P(CC)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sema_busy(sema_busy), .mode_ok(mode_ok),
        .erase_go(erase_go), .erase_addr(erase_addr),
        .erase_kind(erase_kind), .store_go(store_go),
        .store_slot(store_slot), .store_data(store_data),
        .region_prot(region_prot), .ram_mode(ram_mode),
        .mem_mode(mem_mode));

    // Engine model on the far side
    mem_engine_model u_mem (.pclk(pclk), .presetn(presetn),
        .busy_req(busy_req), .mode_req(mode_req), .erase_go(erase_go),
        .erase_addr(erase_addr), .erase_kind(erase_kind),
        .store_go(store_go), .store_slot(store_slot),
        .store_data(store_data), .sema_busy(sema_busy), .mode_ok(mode_ok));

    // Clock and cycle count for timing checks
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) cyc <= cyc + 1;

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One APB transfer; holds everything until pready is sampled
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        check("pready", {31'h0, n < 50}, 32'h1);
    endtask : apb

    // Header bytes go out first byte first
    task automatic msg6(input logic [47:0] m);
        for (int i = 5; i >= 0; i--) apb(1'b1, A_RX, {24'h0, m[i*8 +: 8]});
    endtask : msg6
    task automatic msg7(input logic [55:0] m);
        for (int i = 6; i >= 0; i--) apb(1'b1, A_RX, {24'h0, m[i*8 +: 8]});
    endtask : msg7

    // Poll done, check code and elapsed cycles, then clear done
    task automatic wait_done(input logic [7:0] err, input int lo,
                             input int hi);
        int t0;
        int k;
        t0 = cyc;
        k = 0;
        do begin
            apb(1'b0, A_STAT, 32'h0);
            k++;
        end while (rdat[4] !== 1'b1 && k < 400);
        check("stat_err", {24'h0, rdat[15:8]}, {24'h0, err});
        check("done_time", {31'h0, cyc - t0 >= lo && cyc - t0 <= hi + 9},
              32'h1);
        apb(1'b1, A_CTRL, 32'h1);
    endtask : wait_done

    task automatic do_reset();
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
    endtask : do_reset

    task automatic stop_test();
        $display("Comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test

    // Watchdog far beyond the expected run of under a thousand cycles
    initial begin
        #3000000;
        fail_count++;
        stop_test();
    end

    // Main sequence
    initial begin
        {psel, penable, pwrite, busy_req, rerr} = '0;
        {paddr, pwdata, fail_count, comparisons, cyc} = '0;
        mode_req = 1'b1;
        presetn = 1'b0;
        do_reset();
        apb(1'b0, A_PROT, 32'h0);
        check("prot_reg", rdat, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        check("unmapped", {31'h0, rerr}, 32'h1);
        // Page, sector and whole erase; whole only as end-of-line step
        for (int i = 0; i < 3; i++) begin
            en = u_mem.erase_n;
            msg6({LEN_ERASE, TYPE_ERASE, goff[i], 8'(i)});
            wait_done(ERR_NONE, gcyc[i], gcyc[i]);
            check("erase_n", u_mem.erase_n, en + 1);
            check("erase_addr", u_mem.ea_q, MEM_BASE + {8'h0, goff[i]});
            check("erase_kind", {30'h0, u_mem.ek_q}, i);
        end
        // Refused erases leave memory alone
        en = u_mem.erase_n;
        for (int i = 0; i < 6; i++) begin
            busy_req <= (i == 4);
            mode_req <= (i != 5);
            msg6({LEN_ERASE, TYPE_ERASE, eoff[i], etyp[i]});
            wait_done(eerr[i], 0, 4);
        end
        busy_req <= 1'b0;
        mode_req <= 1'b1;
        msg6({8'h06, TYPE_ERASE, 32'h0});
        wait_done(ERR_COUNT, 0, 4);
        msg7({LEN_ERASE, 8'h8b, 40'h0});
        wait_done(ERR_TYPE, 0, 4);
        check("erase_n", u_mem.erase_n, en);
        // Code segment password stored but not yet applied
        msg7({LEN_PWD, TYPE_PWD, 32'h12345678, 8'h02});
        wait_done(ERR_NONE, CC, CC);
        check("pwd_slot", {29'h0, u_mem.ss_q}, 32'h1);
        check("pwd_data", u_mem.sd_q, 32'h12345678);
        check("prot_now", {28'h0, region_prot}, 32'h0);
        sn = u_mem.store_n;
        msg7({LEN_PWD, TYPE_PWD, 32'h0badf00d, 8'h02});
        wait_done(ERR_PWD_SET, 0, 4);
        msg7({LEN_KEY, TYPE_KEY, SWITCH_KEY ^ 32'h1, 8'h04});
        wait_done(ERR_KEY, 0, 4);
        check("store_n", u_mem.store_n, sn);
        // RAM-test key on every page for robustness
        for (int p = 0; p < 3; p++) begin
            msg7({LEN_KEY, TYPE_KEY, SWITCH_KEY, 8'h04 | 8'(p)});
            wait_done(ERR_NONE, CC, CC);
            check("key_slot", {29'h0, u_mem.ss_q}, 4 + p);
            check("key_data", u_mem.sd_q, SWITCH_KEY);
        end
        // Next reset applies protection and the installed mode
        do_reset();
        repeat (2) @(posedge pclk);
        check("region_prot", {28'h0, region_prot}, 32'h2);
        check("ram_mode", {31'h0, ram_mode}, 32'h1);
        check("mem_mode", {31'h0, mem_mode}, 32'h0);
        apb(1'b0, A_PROT, 32'h0);
        check("prot_reg", rdat, 32'h12);
        en = u_mem.erase_n;
        mode_req <= 1'b1;
        msg6({LEN_ERASE, TYPE_ERASE, 24'h0, ER_ALL});
        wait_done(ERR_WPROT, 0, 4);
        check("erase_n", u_mem.erase_n, en);
        // Reflash prepare erases everything and frees the passwords on its erase strobe
        msg7({LEN_PWD, TYPE_PREP, 40'h0});
        wait_done(ERR_NONE, CL, CL);
        check("prep_kind", {30'h0, u_mem.ek_q}, 32'h2);
        msg7({LEN_PWD, TYPE_PWD, 32'h0badf00d, 8'h02});
        wait_done(ERR_NONE, CC, CC);
        check("pwd_data", u_mem.sd_q, 32'h0badf00d);
        stop_test();
    end
endmodule : nvm_erase_protect_commands_tb
`default_nettype wire
